// file: hw/pies_top.sv
/*
 pies_top: per-pin interrupt qualification for nine input pins, apb slave,
 sticky event status with mask and one level interrupt output.
 assumes: apb master per amba apb, pins asynchronous, one clock pclk.
*/
// The APB slave port was decided locally.
// Overview of operation
// R1 - disabled pin never raises an interrupt
// R2 - enable register, bit n for pin n
// R3 - enabled trigger sets pin interrupt event bit
// R4 - host writes zero to bits 31..9
// R5 - sense 0 high/rising, 1 low/falling
// R6 - sense register, bit n for pin n
// R7 - mode picks level/edge, sense picks polarity
// R8 - optional debounce suppresses short transients
// R9 - mode 0 level, 1 edge
// R10 - both-edges bit overrides sense in edge mode
// R11 - pins synchronised before detection
`timescale 1ns/1ps
`default_nettype none
module pies_top
   import pies_pkg::*;
#(
   parameter int NUM_PINS = PIES_NUM_PINS,
   parameter int DEB_CYC = PIES_DEB_CYC
) (
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PIES_AW-1:0] paddr,
   input wire logic [PIES_DW-1:0] pwdata,
   output logic [PIES_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // pins
   input wire logic [NUM_PINS-1:0] pin_in,
   // interrupt
   output logic irq
);
   initial begin
      if (NUM_PINS != PIES_NUM_PINS) $error("pies_top: NUM_PINS must be 9");
   end
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // zero-extend a pin vector onto the data bus
   function automatic logic [31:0] pies_ext(input logic [8:0] v);
      return {23'h000000, v};
   endfunction : pies_ext
   // decode whether a byte address is a mapped register
   function automatic logic pies_mapped(input logic [7:0] a);
      case (a)
         PIES_OFS_ENABLE, PIES_OFS_SENSE, PIES_OFS_MODE, PIES_OFS_BOTH,
         PIES_OFS_DEBOUNCE, PIES_OFS_STATUS, PIES_OFS_MASK, PIES_OFS_PENDING,
         PIES_OFS_PINS: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : pies_mapped
   // ----------------------------------------------------------------
   // pin filters
   // ----------------------------------------------------------------
   logic [8:0] lvl;  // synchronised, optionally debounced levels
   pies_cfg_s cfg;
   for (genvar i = 0; i < 9; i++) begin : g_pin
      pies_pin_filter #(.DEB_CYC(DEB_CYC)) u_flt (
         .pclk(pclk),
         .presetn(presetn),
         .ce(ce),
         .pin_in(pin_in[i]),
         .deb_en(cfg.debounce[i]),
         .level_out(lvl[i])
      );
   end
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic {PIES_IDLE, PIES_ACCESS} pies_ph_e;
   typedef struct packed {
      pies_cfg_s cfg;         // configuration registers
      logic [8:0] prev;       // previous filtered level, for edges
      logic primed;           // prev is valid; blocks a false edge after reset
      logic [8:0] pending;    // per-pin sticky trigger
      logic status;           // pin_interrupt_event sticky bit
      logic mask;             // interrupt mask
      pies_ph_e ph;           // apb phase
      logic [31:0] rdata;     // read data
      logic ready;            // pready
      logic err;              // pslverr
      logic irq;              // interrupt output
   } pies_st_s;
   pies_st_s st_reg, st_next;
   assign cfg = st_reg.cfg;
   // ----------------------------------------------------------------
   // trigger qualification
   // ----------------------------------------------------------------
   logic [8:0] act;    // level seen through polarity
   logic [8:0] rise;
   logic [8:0] fall;
   logic [8:0] trig;   // per-pin qualified condition
   always_comb begin
      act = lvl ^ cfg.sense;  // R5 R6
      rise = st_reg.primed ? (lvl & ~st_reg.prev) : 9'h000;
      fall = st_reg.primed ? (~lvl & st_reg.prev) : 9'h000;
      for (int i = 0; i < 9; i++) begin
         if (!cfg.mode[i]) begin
            trig[i] = act[i];  // R7 R9
         end else if (cfg.both[i]) begin
            trig[i] = rise[i] | fall[i];  // R10
         end else begin
            trig[i] = cfg.sense[i] ? fall[i] : rise[i];  // R5 R7
         end
      end
      trig = trig & cfg.enable;  // R1 R2
   end
   // ----------------------------------------------------------------
   // next state: apb access, sticky status, interrupt
   // ----------------------------------------------------------------
   logic wr_acc;        // write access taken this cycle
   logic rd_setup;      // setup cycle of a read or write
   logic [8:0] clr_pend;
   logic clr_stat;
   always_comb begin
      st_next = st_reg;
      wr_acc = 1'b0;
      rd_setup = psel && !penable;
      clr_pend = 9'h000;
      clr_stat = 1'b0;
      st_next.prev = lvl;
      st_next.primed = 1'b1;
      st_next.ready = 1'b0;
      st_next.err = 1'b0;
      case (st_reg.ph)
         PIES_IDLE: begin
            // setup seen: answer in the next (access) cycle, one wait-free
            if (rd_setup) begin
               st_next.ph = PIES_ACCESS;
               st_next.ready = 1'b1;
               st_next.err = !pies_mapped(paddr);
               st_next.rdata = 32'h00000000;
               if (!pwrite) begin
                  case (paddr)
                     PIES_OFS_ENABLE: st_next.rdata = pies_ext(cfg.enable);
                     PIES_OFS_SENSE: st_next.rdata = pies_ext(cfg.sense);
                     PIES_OFS_MODE: st_next.rdata = pies_ext(cfg.mode);
                     PIES_OFS_BOTH: st_next.rdata = pies_ext(cfg.both);
                     PIES_OFS_DEBOUNCE: st_next.rdata = pies_ext(cfg.debounce);
                     PIES_OFS_STATUS: st_next.rdata = {31'h00000000, st_reg.status};
                     PIES_OFS_MASK: st_next.rdata = {31'h00000000, st_reg.mask};
                     PIES_OFS_PENDING: st_next.rdata = pies_ext(st_reg.pending);
                     PIES_OFS_PINS: st_next.rdata = pies_ext(lvl);
                     default: st_next.rdata = 32'h00000000;
                  endcase
               end
            end
         end
         PIES_ACCESS: begin
            // access completes at this edge since pready is high
            st_next.ph = PIES_IDLE;
            wr_acc = psel && penable && pwrite;
         end
         default: st_next.ph = PIES_IDLE;
      endcase
      if (wr_acc) begin
         // upper bits are dropped; software keeps them zero R4
         case (paddr)
            PIES_OFS_ENABLE: st_next.cfg.enable = pwdata[8:0];  // R2
            PIES_OFS_SENSE: st_next.cfg.sense = pwdata[8:0];  // R6
            PIES_OFS_MODE: st_next.cfg.mode = pwdata[8:0];  // R9
            PIES_OFS_BOTH: st_next.cfg.both = pwdata[8:0];  // R10
            PIES_OFS_DEBOUNCE: st_next.cfg.debounce = pwdata[8:0];  // R8
            PIES_OFS_STATUS: clr_stat = pwdata[PIES_EVT_BIT];
            PIES_OFS_MASK: st_next.mask = pwdata[PIES_EVT_BIT];
            PIES_OFS_PENDING: clr_pend = pwdata[8:0];
            default: ;
         endcase
      end
      // set wins over clear so no trigger is lost
      st_next.pending = (st_reg.pending & ~clr_pend) | trig;
      st_next.status = (st_reg.status & ~clr_stat) | (|trig);  // R3
      st_next.irq = st_next.status & st_next.mask;
   end
   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg.cfg <= '{default: PIES_CFG_RESET};
         st_reg.prev <= 9'h000;
         st_reg.primed <= 1'b0;
         st_reg.pending <= 9'h000;
         st_reg.status <= 1'b0;
         st_reg.mask <= PIES_MASK_RESET;
         st_reg.ph <= PIES_IDLE;
         st_reg.rdata <= 32'h00000000;
         st_reg.ready <= 1'b0;
         st_reg.err <= 1'b0;
         st_reg.irq <= 1'b0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end
   assign prdata = st_reg.rdata;
   assign pready = st_reg.ready;
   assign pslverr = st_reg.err;
   assign irq = st_reg.irq;
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_disabled_no_pend: assert property (@(posedge pclk) disable iff (!presetn)
      ce && !cfg.enable[0] && !st_reg.pending[0] |=> !st_reg.pending[0]) // R1
      else $error("disabled pin 0 set pending");
   a_enable_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
      ce && wr_acc && paddr == PIES_OFS_ENABLE |=> cfg.enable == $past(pwdata[8:0])) // R2
      else $error("enable write not stored");
   a_trig_sets_event: assert property (@(posedge pclk) disable iff (!presetn)
      ce && (|trig) |=> st_reg.status && irq == st_reg.mask) // R3
      else $error("trigger did not set event");
   a_level_high_pend: assert property (@(posedge pclk) disable iff (!presetn)
      ce && cfg.enable[0] && !cfg.mode[0] && !cfg.sense[0] && lvl[0]
      |=> st_reg.pending[0]) // R5
      else $error("high level did not set pending");
   a_sense_low_pend: assert property (@(posedge pclk) disable iff (!presetn)
      ce && cfg.enable[3] && !cfg.mode[3] && cfg.sense[3] && !lvl[3]
      |=> st_reg.pending[3]) // R6
      else $error("low level did not set pending");
   a_edge_rise_only: assert property (@(posedge pclk) disable iff (!presetn)
      cfg.mode[0] && !cfg.both[0] && !cfg.sense[0] && trig[0]
      |-> lvl[0] && !st_reg.prev[0]) // R7 R9
      else $error("rising edge mode fired without rise");
   a_both_edges: assert property (@(posedge pclk) disable iff (!presetn)
      cfg.enable[5] && cfg.mode[5] && cfg.both[5] && st_reg.primed
      && lvl[5] != st_reg.prev[5] |-> trig[5]) // R10
      else $error("both-edge mode missed an edge");
   a_irq_follows_mask: assert property (@(posedge pclk) disable iff (!presetn)
      irq |-> $past(st_next.status && st_next.mask)) // R3
      else $error("irq without masked status");
   a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
      ce && psel && !penable && st_reg.ph == PIES_IDLE |=> pready) // APB port, decided locally
      else $error("apb answer late");
endmodule : pies_top
`default_nettype wire

// file: hw/pies_pkg.sv
/*
 pies_pkg: register map, field layout, reset values and carrier types of the
 pin interrupt enable and sense block.
 assumes: a 32-bit apb slave with word-aligned registers.
*/
package pies_pkg;
   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int PIES_NUM_PINS = 9;          // pins 0..8
   localparam int PIES_DW = 32;               // apb data width
   localparam int PIES_AW = 8;                // apb address width used
   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] PIES_OFS_ENABLE = 8'h10;    // pin_irq_enable
   localparam logic [7:0] PIES_OFS_SENSE = 8'h14;     // pin_irq_sense
   localparam logic [7:0] PIES_OFS_MODE = 8'h18;      // pin_irq_level_edge_mode
   localparam logic [7:0] PIES_OFS_BOTH = 8'h1C;      // pin_irq_both_edges
   localparam logic [7:0] PIES_OFS_DEBOUNCE = 8'h24;  // pin_irq_debounce_enable
   localparam logic [7:0] PIES_OFS_STATUS = 8'h28;    // event status, write one to clear
   localparam logic [7:0] PIES_OFS_MASK = 8'h2C;      // event mask
   localparam logic [7:0] PIES_OFS_PENDING = 8'h30;   // per-pin pending, write one to clear
   localparam logic [7:0] PIES_OFS_PINS = 8'h34;      // synchronised pin levels, read only
   // ----------------------------------------------------------------
   // status fields and reset values
   // ----------------------------------------------------------------
   localparam int PIES_EVT_BIT = 0;                   // pin_interrupt_event position
   localparam logic [8:0] PIES_CFG_RESET = 9'h000;    // all pins disabled
   localparam logic [0:0] PIES_MASK_RESET = 1'h0;     // interrupt masked
   // ----------------------------------------------------------------
   // timing: debounce hold time
   // ----------------------------------------------------------------
   localparam int PIES_CLK_NS = 10;                   // 100 MHz pclk
   localparam int PIES_DEB_NS = 40;                   // least stable time
   localparam int PIES_DEB_CYC = (PIES_DEB_NS + PIES_CLK_NS - 1) / PIES_CLK_NS;
   // ----------------------------------------------------------------
   // carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [8:0] enable;     // pin_irq_enable
      logic [8:0] sense;      // pin_irq_sense
      logic [8:0] mode;       // pin_irq_level_edge_mode
      logic [8:0] both;       // pin_irq_both_edges
      logic [8:0] debounce;   // pin_irq_debounce_enable
   } pies_cfg_s;
endpackage : pies_pkg

// file: hw/pies_pin_filter.sv
/*
 pies_pin_filter: synchroniser and optional debounce for one pin.
 assumes: pin_in is asynchronous; pclk 100 MHz; ce freezes state.
*/
`timescale 1ns/1ps
`default_nettype none
module pies_pin_filter
   import pies_pkg::*;
#(
   parameter int DEB_CYC = PIES_DEB_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // pin side
   input wire logic pin_in,
   input wire logic deb_en,
   // filtered level
   output logic level_out
);
   initial begin
      if (DEB_CYC < 1 || DEB_CYC > 255) $error("pies_pin_filter: DEB_CYC out of range");
   end
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic s1;           // first sync stage, read only by s2
      logic s2;           // second sync stage
      logic lvl;          // filtered level
      logic [7:0] cnt;    // stability counter
   } pies_flt_s;
   pies_flt_s st_reg, st_next;
   // next state: debounce only accepts a level held DEB_CYC cycles
   always_comb begin
      st_next = st_reg;
      st_next.s1 = pin_in;
      st_next.s2 = st_reg.s1;  // R11
      if (!deb_en) begin
         // bypass: one cycle of added latency beyond the synchroniser
         st_next.lvl = st_reg.s2;
         st_next.cnt = 8'h00;
      end else if (st_reg.s2 == st_reg.lvl) begin
         st_next.cnt = 8'h00;
      end else if (st_reg.cnt == 8'(DEB_CYC - 1)) begin
         st_next.lvl = st_reg.s2;  // R8
         st_next.cnt = 8'h00;
      end else begin
         st_next.cnt = st_reg.cnt + 8'h01;  // short pulses count here but never reach DEB_CYC
      end
   end
   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end
   assign level_out = st_reg.lvl;
endmodule : pies_pin_filter
`default_nettype wire

// file: sim/pies_pin_model.sv
/*
 pies_pin_model: the outside world at the nine interrupt pins.
 assumes: the bench asks for levels and one-cycle glitches on pclk edges.
*/
`timescale 1ns/1ps
`default_nettype none
module pies_pin_model
   import pies_pkg::*;
(
   // clock
   input wire logic pclk,
   // requests from the bench
   input wire logic [PIES_NUM_PINS-1:0] want,
   input wire logic [PIES_NUM_PINS-1:0] glitch,
   // pins
   output logic [PIES_NUM_PINS-1:0] pin_in
);
   // ----------------------------------------------------------------
   // pin drive
   // ----------------------------------------------------------------
   // a glitch flips a pin for one cycle, shorter than the debounce hold
   always @(posedge pclk) begin
      pin_in <= want ^ glitch;
   end
endmodule : pies_pin_model
`default_nettype wire

// file: sim/pies_top_tb.sv
/*
 pies_top_tb: self-checking bench for the pin interrupt block over apb.
 assumes: pies_top and pies_pin_model compiled before this file.
*/
`timescale 1ns/1ps
`default_nettype none
module pies_top_tb;
   import pies_pkg::*;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   localparam int TB_DEB = 2;   // short hold keeps the run brief
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [PIES_AW-1:0] paddr;
   logic [PIES_DW-1:0] pwdata, prdata, r;
   logic [8:0] want, glitch, pin_in, b;
   logic e;
   int err_total, cmp_count, cyc;
   pies_top #(.NUM_PINS(PIES_NUM_PINS), .DEB_CYC(TB_DEB)) i_pies_top (.pclk(pclk),
      .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_in(pin_in), .irq(irq));
   pies_pin_model i_pies_pin_model (.pclk(pclk), .want(want), .glitch(glitch),
      .pin_in(pin_in));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task stop_test();
      $display("compares=%0d mismatches=%0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one transfer; idle edge first so release and next setup never collide
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(r, exp);
   endtask : rd_chk
   // wait for pins to settle, then drop every sticky bit
   task settle_clr();
      repeat (8) @(posedge pclk);
      wr(PIES_OFS_PENDING, 32'h000001FF);
      wr(PIES_OFS_STATUS, 32'h00000001);
   endtask : settle_clr
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_regs();
      rd_chk(PIES_OFS_ENABLE, 32'h0);
      rd_chk(PIES_OFS_SENSE, 32'h0);
      rd_chk(PIES_OFS_MODE, 32'h0);
      rd_chk(PIES_OFS_MASK, 32'h0);
      wr(PIES_OFS_ENABLE, 32'h000001A5);
      rd_chk(PIES_OFS_ENABLE, 32'h000001A5);
      wr(PIES_OFS_SENSE, 32'h0000005A);
      rd_chk(PIES_OFS_SENSE, 32'h0000005A);
      apb(1'b0, 8'h00, 32'h0);
      chk({31'h0, e}, 32'h1);
      wr(PIES_OFS_ENABLE, 32'h0);
      wr(PIES_OFS_SENSE, 32'h0);
   endtask : t_regs
   // all pins high at level mode: nothing while disabled, all once enabled
   task t_enable();
      wr(PIES_OFS_MASK, 32'h1);
      want <= 9'h1FF;
      settle_clr();
      repeat (8) @(posedge pclk);
      rd_chk(PIES_OFS_STATUS, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(PIES_OFS_ENABLE, 32'h000001FF);
      repeat (8) @(posedge pclk);
      rd_chk(PIES_OFS_PENDING, 32'h000001FF);
      chk({31'h0, irq}, 32'h1);
      wr(PIES_OFS_ENABLE, 32'h0);
      want <= 9'h000;
      settle_clr();
   endtask : t_enable
   // every pin, both senses, edge mode; the opposite edge must stay silent
   task t_polarity();
      wr(PIES_OFS_MODE, 32'h000001FF);
      for (int n = 0; n < PIES_NUM_PINS; n++) begin
         for (int s = 0; s < 2; s++) begin
            b = 9'h001 << n;
            wr(PIES_OFS_SENSE, (s == 1) ? {23'h0, b} : 32'h0);
            wr(PIES_OFS_ENABLE, {23'h0, b});
            want <= (s == 1) ? b : 9'h000;
            settle_clr();
            want <= (s == 1) ? 9'h000 : b;
            repeat (8) @(posedge pclk);
            rd_chk(PIES_OFS_PENDING, {23'h0, b});
            rd_chk(PIES_OFS_STATUS, 32'h1);
            // clear first, so only the opposite edge could set it again
            wr(PIES_OFS_PENDING, 32'h000001FF);
            wr(PIES_OFS_STATUS, 32'h00000001);
            want <= (s == 1) ? b : 9'h000;
            repeat (8) @(posedge pclk);
            rd_chk(PIES_OFS_PENDING, 32'h0);
         end
      end
   endtask : t_polarity
   // low level on pin 3 retriggers after clear; mask gates the output
   task t_level();
      wr(PIES_OFS_MODE, 32'h0);
      wr(PIES_OFS_SENSE, 32'h8);
      wr(PIES_OFS_ENABLE, 32'h8);
      want <= 9'h008;
      settle_clr();
      rd_chk(PIES_OFS_PENDING, 32'h0);
      want <= 9'h000;
      settle_clr();
      rd_chk(PIES_OFS_PENDING, 32'h8);
      chk({31'h0, irq}, 32'h1);
      wr(PIES_OFS_MASK, 32'h0);
      repeat (3) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      wr(PIES_OFS_MASK, 32'h1);
      want <= 9'h008;
      settle_clr();
      rd_chk(PIES_OFS_STATUS, 32'h0);
   endtask : t_level
   // both-edges override, then a debounced glitch versus a held level
   task t_both_deb();
      wr(PIES_OFS_MODE, 32'h000001FF);
      wr(PIES_OFS_SENSE, 32'h0);
      wr(PIES_OFS_BOTH, 32'h20);
      wr(PIES_OFS_ENABLE, 32'h20);
      want <= 9'h020;
      settle_clr();
      want <= 9'h000;
      repeat (8) @(posedge pclk);
      rd_chk(PIES_OFS_PENDING, 32'h20);
      wr(PIES_OFS_DEBOUNCE, 32'h4);
      wr(PIES_OFS_ENABLE, 32'h4);
      settle_clr();
      glitch <= 9'h004;
      @(posedge pclk);
      glitch <= 9'h000;
      repeat (10) @(posedge pclk);
      rd_chk(PIES_OFS_PENDING, 32'h0);
      want <= 9'h004;
      repeat (10) @(posedge pclk);
      rd_chk(PIES_OFS_PENDING, 32'h4);
   endtask : t_both_deb
   // ----------------------------------------------------------------
   // clock, timeout, main sequence
   // ----------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // the whole run needs about 1200 cycles; a hang stops here
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         stop_test();
      end
   end
   initial begin
      {presetn, psel, penable, pwrite} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      want = 9'h000;
      glitch = 9'h000;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_enable();
      t_polarity();
      t_level();
      t_both_deb();
      stop_test();
   end
endmodule : pies_top_tb
`default_nettype wire
